/* hw/vrts_pkg.sv */
// Purpose: Shared constants and types of the VRAM row-transfer sequencer
// Assumes: clk is the free-running serial clock, one quarter of the dot rate
// Notes: Counts are in serial clock periods
package vrts_pkg;
    // Clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_RATE_HZ = 1000000000 / CLK_PERIOD_NS;
    localparam int DOTS_PER_SERIAL = 4;

    // Widths
    localparam int ROW_W = 22;
    localparam int BUS_W = 24;
    localparam int CNT_W = 16;
    localparam int ROW_LSB = 2;

    // Reset values
    localparam logic [ROW_W-1:0] ROW_RESET = 22'h000000;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [BUS_W-1:0] BUS_RESET = 24'h000000;

    // Internal overhead after each transfer, before the pre-request count, in serial periods
    localparam logic [CNT_W-1:0] OVERHEAD_CYCLES = 16'h0001;

    // Row steps
    localparam logic [ROW_W-1:0] STEP_1 = 22'h000001;
    localparam logic [ROW_W-1:0] STEP_2 = 22'h000002;
    localparam logic [ROW_W-1:0] STEP_256 = 22'h000100;
    localparam logic [ROW_W-1:0] STEP_512 = 22'h000200;
    localparam logic [ROW_W-1:0] STEP_1024 = 22'h000400;
    localparam logic [ROW_W-1:0] OFFSET_0 = 22'h000000;

    // Step select codes
    localparam logic [1:0] CODE_A = 2'h0;
    localparam logic [1:0] CODE_B = 2'h1;
    localparam logic [1:0] CODE_C = 2'h2;
    localparam logic [1:0] CODE_D = 2'h3;

    // Sequencer states
    typedef enum logic [2:0] {
        VRTS_IDLE = 3'b000,
        VRTS_PRE = 3'b001,
        VRTS_DEFER = 3'b010,
        VRTS_REQ = 3'b011,
        VRTS_XFER = 3'b100,
        VRTS_OVHD = 3'b101
    } vrts_state_t;
endpackage : vrts_pkg

/* hw/vrts_count.sv */
// Purpose: Loadable down-counter of serial clock periods
// Assumes: Load wins over decrement
// Notes: done is combinational from the count, stops at zero
module vrts_count (
    input wire logic clk, // Serial clock
    input wire logic resetn, // Async reset, active low
    input wire logic load, // Load value
    input wire logic [vrts_pkg::CNT_W-1:0] value, // Value to load
    input wire logic dec_en, // Count one period
    output logic done // Count has reached zero
);
    import vrts_pkg::*;

    logic [CNT_W-1:0] count;

    // Count down, hold at zero so a late check still sees done
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= CNT_RESET;
        end else if (load) begin
            count <= value;
        end else if (dec_en && count != CNT_RESET) begin
            count <= count - 16'h0001;
        end
    end

    assign done = (count == CNT_RESET);
endmodule : vrts_count

/* hw/vrts_step.sv */
// Purpose: Row step and second-field offset from the format code
// Assumes: Code and interlace only change while the timing generator is off
// Notes: Pure combinational decode
module vrts_step (
    input wire logic [1:0] code, // Step code
    input wire logic interlace, // Interlace format
    output logic [vrts_pkg::ROW_W-1:0] step, // Row step per transfer
    output logic [vrts_pkg::ROW_W-1:0] offset // Second field start offset
);
    import vrts_pkg::*;

    // Decode step and field offset
    always_comb begin
        step = STEP_1;
        offset = OFFSET_0;
        unique case (code)
            CODE_A: begin
                step = STEP_1;
                offset = OFFSET_0;
            end
            CODE_B: begin
                step = interlace ? STEP_2 : STEP_256;
                offset = interlace ? STEP_1 : OFFSET_0;
            end
            CODE_C: begin
                step = STEP_512;
                offset = interlace ? STEP_256 : OFFSET_0;
            end
            CODE_D: begin
                step = STEP_1024;
                offset = interlace ? STEP_512 : OFFSET_0;
            end
        endcase
    end
endmodule : vrts_step

/* hw/vrts_sequencer.sv */
// Purpose: VRAM row-transfer sequencer: row address, bus request, grant and
//          row load strobe timing from a pre-request count and a transfer lag
// Assumes: All inputs synchronous to clk; clk is the serial clock itself
// Notes: The timing generator supplies frame, back porch, flyback and field
//        marks; VRAM strobes are built outside from these outputs

// Operation
// - Drive fresh 22-bit row on bus bits 2-23
// - First frame address from frame origin pointer
// - Line alias when stopped, frame alias when running
// - Non-interlace steps 1, 256, 512, 1024
// - Interlace steps 1, 2, 512, 1024 plus offsets
// - Column part of address never incremented
// - New origin takes effect next frame or field
// - Interlace blanks first half of line zero
// - Field order follows CCIR or NTSC standard
// - Frame transfer launched at first back porch
// - Request after pre-request count elapses
// - Grant answers request; strobe and address follow
// - Release strobe on shift edge after lag
// - Transfer period is pre-request plus lag; the code takes pre-request plus lag plus 3 periods
// - One overhead period outside request-to-strobe span
// - Pending transfer at flyback cancelled, restarted later
// - Predict line end and defer reload
// - Deferred lag carried over, resumes in display
// - Serial clock paces counts at dot rate/4
module vrts_sequencer (
    input wire logic clk, // Serial clock
    input wire logic resetn, // Async reset, active low
    input wire logic vtg_enable, // Timing generator running
    input wire logic [1:0] step_code, // Row step select
    input wire logic interlace, // Interlace format
    input wire logic standard_ntsc, // 1: NTSC order, 0: CCIR order
    input wire logic [vrts_pkg::CNT_W-1:0] pre_request_count, // Periods before request
    input wire logic [vrts_pkg::CNT_W-1:0] transfer_lag, // Periods request to transfer
    input wire logic [vrts_pkg::ROW_W-1:0] origin_wdata, // Origin pointer write data
    input wire logic origin_wr_line, // Write through line origin alias
    input wire logic origin_wr_frame, // Write through frame origin alias
    input wire logic frame_start, // Pulse: back porch of first line
    input wire logic backporch_start, // Pulse: back porch of a line
    input wire logic flyback, // Level: frame flyback
    input wire logic active_display, // Level: active display
    input wire logic field_index, // 0: first field, 1: second field
    input wire logic line_zero_first_half, // Level: first half of line zero
    input wire logic [vrts_pkg::CNT_W-1:0] line_remaining, // Periods left in line
    input wire logic shift_edge, // Pulse: shift clock edge
    input wire logic bus_grant_in, // Host grants bus
    output logic bus_request_out, // Bus request, active high
    output logic vram_transfer_n, // Row load strobe, active low
    output logic [vrts_pkg::BUS_W-1:0] shared_addr_data_bus_out, // Bus drive value
    output logic shared_addr_data_bus_oe, // Bus drive enable
    output logic [vrts_pkg::ROW_W-1:0] origin_rdata, // Origin pointer readback
    output logic blank_video, // Blank video outputs
    output logic transfer_done, // Pulse: row transfer performed
    output logic transfer_deferred // Level: transfer waiting for back porch
);
    import vrts_pkg::*;

    vrts_state_t state;
    vrts_state_t next_state;
    logic [ROW_W-1:0] origin_pending;
    logic [ROW_W-1:0] origin_active;
    logic [ROW_W-1:0] row;
    logic [ROW_W-1:0] step;
    logic [ROW_W-1:0] offset;
    logic lag_hold;
    logic pre_done;
    logic lag_done;
    logic pre_load;
    logic lag_load;
    logic lag_dec;
    logic frame_launch;
    logic defer_now;
    logic release_now;
    logic second_field;

    // Frame launch may pre-empt idle, pre-request and deferred states but never a request or transfer
    assign frame_launch = vtg_enable && frame_start &&
        (state == VRTS_IDLE || state == VRTS_PRE || state == VRTS_DEFER);

    // Flyback cancels, or data lasts past line end so reload can wait
    assign defer_now = flyback || (transfer_lag >= line_remaining);

    // Transfer only on a shift clock edge once the lag is spent
    assign release_now = (state == VRTS_XFER) && lag_done && shift_edge;

    // NTSC scans odd lines first, so its first field takes the offset
    assign second_field = interlace && (field_index ^ standard_ntsc);

    // Counter controls
    assign pre_load = (state == VRTS_OVHD);
    assign lag_load = frame_launch || (state == VRTS_PRE && pre_done);
    assign lag_dec = (state == VRTS_REQ || state == VRTS_XFER) &&
        (!lag_hold || active_display);

    // Pre-request counter, one tick per serial period
    vrts_count u_pre_count (
        .clk(clk),
        .resetn(resetn),
        .load(pre_load),
        .value(pre_request_count),
        .dec_en(state == VRTS_PRE),
        .done(pre_done)
    );

    // Transfer lag counter, started with the request
    vrts_count u_lag_count (
        .clk(clk),
        .resetn(resetn),
        .load(lag_load),
        .value(transfer_lag),
        .dec_en(lag_dec),
        .done(lag_done)
    );

    // Step and offset decode
    vrts_step u_step (
        .code(step_code),
        .interlace(interlace),
        .step(step),
        .offset(offset)
    );

    // Next state
    always_comb begin
        next_state = state;
        if (!vtg_enable) begin
            next_state = VRTS_IDLE;
        end else if (frame_launch) begin
            next_state = VRTS_REQ;
        end else begin
            unique case (state)
                VRTS_IDLE: begin
                    next_state = VRTS_IDLE;
                end
                VRTS_PRE: begin
                    if (pre_done) begin
                        next_state = defer_now ? VRTS_DEFER : VRTS_REQ;
                    end
                end
                VRTS_DEFER: begin
                    if (backporch_start && !flyback) begin
                        next_state = VRTS_REQ;
                    end
                end
                VRTS_REQ: begin
                    if (bus_grant_in) begin
                        next_state = VRTS_XFER;
                    end
                end
                VRTS_XFER: begin
                    if (release_now) begin
                        next_state = VRTS_OVHD;
                    end
                end
                VRTS_OVHD: begin
                    next_state = VRTS_PRE;
                end
                default: begin
                    next_state = VRTS_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= VRTS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Deferred transfers hold their lag until active display starts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lag_hold <= 1'b0;
        end else if (!vtg_enable || frame_launch) begin
            lag_hold <= 1'b0;
        end else if (state == VRTS_DEFER && next_state == VRTS_REQ) begin
            lag_hold <= 1'b1;
        end else if (active_display) begin
            lag_hold <= 1'b0;
        end
    end

    // Origin pointer: each alias is live only in its own generator state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            origin_pending <= ROW_RESET;
        end else if (origin_wr_line && !vtg_enable) begin
            origin_pending <= origin_wdata;
        end else if (origin_wr_frame && vtg_enable) begin
            origin_pending <= origin_wdata;
        end
    end

    // Pointer in use is sampled only at the top of a frame or field
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            origin_active <= ROW_RESET;
        end else if (frame_launch) begin
            origin_active <= origin_pending;
        end
    end

    // Readback shows the written value, not the one in use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            origin_rdata <= ROW_RESET;
        end else begin
            origin_rdata <= origin_pending;
        end
    end

    // Row address: reload at frame top, step after each transfer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            row <= ROW_RESET;
        end else if (frame_launch) begin
            row <= origin_pending + (second_field ? offset : OFFSET_0);
        end else if (release_now) begin
            row <= row + step;
        end
    end

    // Bus request spans request and strobe, drops with the transfer edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_request_out <= 1'b0;
        end else begin
            bus_request_out <= vtg_enable &&
                (next_state == VRTS_REQ || next_state == VRTS_XFER);
        end
    end

    // Row load strobe low from grant until the first shift edge after the lag has run out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vram_transfer_n <= 1'b1;
        end else begin
            vram_transfer_n <= !(vtg_enable && next_state == VRTS_XFER);
        end
    end

    // Address drive while granted; column bits stay at zero, the host owns them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shared_addr_data_bus_out <= BUS_RESET;
            shared_addr_data_bus_oe <= 1'b0;
        end else if (vtg_enable && next_state == VRTS_XFER) begin
            shared_addr_data_bus_out <= {row, 2'h0};
            shared_addr_data_bus_oe <= 1'b1;
        end else begin
            shared_addr_data_bus_out <= BUS_RESET;
            shared_addr_data_bus_oe <= 1'b0;
        end
    end

    // Blank only the DACs; shift clocking is untouched by this block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blank_video <= 1'b0;
        end else begin
            blank_video <= vtg_enable && interlace && line_zero_first_half;
        end
    end

    // Status: one pulse per performed transfer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transfer_done <= 1'b0;
        end else begin
            transfer_done <= release_now && vtg_enable;
        end
    end

    // Status: waiting for the next active back porch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transfer_deferred <= 1'b0;
        end else begin
            transfer_deferred <= vtg_enable && next_state == VRTS_DEFER;
        end
    end
endmodule : vrts_sequencer

/* tb/vrts_host_model.sv */
// Purpose: Host model granting the shared bus to the row-transfer sequencer
// Assumes: Grant latency is programmed below the transfer lag
// Notes: Grant falls as soon as the request goes away
module vrts_host_model (
    input wire logic clk, // Serial clock
    input wire logic resetn, // Async reset, active low
    input wire logic bus_request_out, // Request from sequencer
    input wire logic [3:0] grant_delay, // Grant latency in periods
    output logic bus_grant_in // Grant to sequencer
);
    logic [3:0] wait_cnt;

    // A slow host leaves the sequencer waiting in request; latency kept inside the lag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= 4'h0;
            bus_grant_in <= 1'b0;
        end else if (!bus_request_out) begin
            wait_cnt <= 4'h0; // Bus returns to host with the request
            bus_grant_in <= 1'b0;
        end else if (wait_cnt >= grant_delay) begin
            bus_grant_in <= 1'b1; // Answer the request
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : vrts_host_model

/* tb/vrts_sequencer_sva.sv */
// Purpose: Port-level checks of the row-transfer sequencer
// Assumes: Single clock domain, reset active low
// Notes: Gap check is skipped across defers and restarts
module vrts_sequencer_sva (
    input wire logic clk, // Serial clock
    input wire logic resetn, // Async reset
    input wire logic vtg_enable, // Timing generator running
    input wire logic interlace, // Interlace format
    input wire logic [vrts_pkg::CNT_W-1:0] pre_request_count, // Pre-request count
    input wire logic frame_start, // Frame back porch pulse
    input wire logic backporch_start, // Line back porch pulse
    input wire logic flyback, // Flyback level
    input wire logic line_zero_first_half, // First half of line zero
    input wire logic shift_edge, // Shift clock edge
    input wire logic bus_grant_in, // Host grant
    input wire logic bus_request_out, // Bus request
    input wire logic vram_transfer_n, // Row load strobe
    input wire logic [vrts_pkg::BUS_W-1:0] shared_addr_data_bus_out, // Bus value
    input wire logic shared_addr_data_bus_oe, // Bus enable
    input wire logic blank_video, // Blanking
    input wire logic transfer_done, // Transfer pulse
    input wire logic transfer_deferred // Deferred level
);
    import vrts_pkg::*;
    logic [16:0] low_run;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Length of the request-low run after a transfer; any defer or restart breaks the chain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) low_run <= 17'h00000;
        else if (transfer_deferred || frame_start || !vtg_enable) low_run <= 17'h00000;
        else if (transfer_done) low_run <= 17'h00001;
        else if (low_run != 17'h00000 && !bus_request_out) low_run <= low_run + 17'h00001;
    end

    sequence s_granted; bus_request_out && vram_transfer_n && bus_grant_in && vtg_enable; endsequence
    sequence s_strobing; !vram_transfer_n && shared_addr_data_bus_oe; endsequence

    property p_req_start;
        vtg_enable && frame_start && !bus_request_out && !transfer_done |=> bus_request_out;
    endproperty
    property p_grant_strobe; s_granted |=> s_strobing; endproperty
    property p_bus;
        shared_addr_data_bus_oe |-> s_strobing and bus_request_out && shared_addr_data_bus_out[1:0] == 2'h0;
    endproperty
    property p_drop;
        $rose(vram_transfer_n) && $past(vtg_enable) && vtg_enable |-> $fell(bus_request_out) && transfer_done;
    endproperty
    property p_shift;
        $fell(bus_request_out) && $past(vtg_enable) |-> $past(shift_edge) && !$past(vram_transfer_n);
    endproperty
    property p_gap;
        $rose(bus_request_out) && low_run != 17'h00000 |-> low_run == {1'b0, pre_request_count} + 17'h00002;
    endproperty
    property p_restart; transfer_deferred && backporch_start && !flyback && vtg_enable |=> bus_request_out; endproperty
    property p_abort; !vtg_enable |=> !bus_request_out && vram_transfer_n && !shared_addr_data_bus_oe; endproperty
    property p_blank; 1'b1 |=> blank_video == $past(vtg_enable && interlace && line_zero_first_half); endproperty

    a_req_start: assert property (p_req_start) else $error("no request after frame start");
    a_grant_strobe: assert property (p_grant_strobe) else $error("no strobe after grant");
    a_bus: assert property (p_bus) else $error("bus drive outside strobe");
    a_drop: assert property (p_drop) else $error("strobe and request not released together");
    a_shift: assert property (p_shift) else $error("release off shift edge");
    a_gap: assert property (p_gap) else $error("pre-request gap wrong");
    a_restart: assert property (p_restart) else $error("deferred transfer not restarted");
    a_abort: assert property (p_abort) else $error("outputs active while stopped");
    a_blank: assert property (p_blank) else $error("blanking wrong");
endmodule : vrts_sequencer_sva

bind vrts_sequencer vrts_sequencer_sva u_sva (.clk, .resetn, .vtg_enable, .interlace, .pre_request_count,
    .frame_start, .backporch_start, .flyback, .line_zero_first_half, .shift_edge, .bus_grant_in,
    .bus_request_out, .vram_transfer_n, .shared_addr_data_bus_out, .shared_addr_data_bus_oe,
    .blank_video, .transfer_done, .transfer_deferred);

/* tb/test_vrts_sequencer.sv */
// Purpose: Self-checking bench of the row-transfer sequencer
// Assumes: Inputs change on the falling edge, lag 6 and pre-request 4
// Notes: Deferred restarts carry the old lag, so their span is not checked
module test_vrts_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import vrts_pkg::*;
    localparam logic [CNT_W-1:0] LAG = 16'h0006; // Inside porch and shift length bounds
    localparam logic [CNT_W-1:0] PRE_N = 16'h0004;
    localparam logic [ROW_W-1:0] ORG = 22'h012340;
    localparam logic [ROW_W-1:0] ORG2 = 22'h0a0000;
    logic clk, resetn, vtg_enable, interlace, standard_ntsc, origin_wr_line, origin_wr_frame;
    logic frame_start, backporch_start, flyback, field_index, line_zero_first_half, shift_edge;
    logic bus_grant_in, bus_request_out, vram_transfer_n, shared_addr_data_bus_oe, blank_video;
    logic transfer_done, transfer_deferred, active_display;
    logic [1:0] step_code;
    logic [3:0] grant_delay;
    logic [CNT_W-1:0] line_remaining;
    logic [ROW_W-1:0] origin_wdata, origin_rdata, r0, r1;
    logic [BUS_W-1:0] shared_addr_data_bus_out;
    logic [ROW_W-1:0] non_tab [4] = '{22'h000001, 22'h000100, 22'h000200, 22'h000400};
    logic [ROW_W-1:0] int_tab [4] = '{22'h000001, 22'h000002, 22'h000200, 22'h000400};
    logic [ROW_W-1:0] off_tab [4] = '{22'h000000, 22'h000001, 22'h000100, 22'h000200};
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // VRAM strobes would be formed outside from request, strobe and clocks
    vrts_sequencer dut (.clk, .resetn, .vtg_enable, .step_code, .interlace, .standard_ntsc,
        .pre_request_count(PRE_N), .transfer_lag(LAG), .origin_wdata, .origin_wr_line, .origin_wr_frame,
        .frame_start, .backporch_start, .flyback, .active_display, .field_index, .line_zero_first_half,
        .line_remaining, .shift_edge, .bus_grant_in, .bus_request_out, .vram_transfer_n,
        .shared_addr_data_bus_out, .shared_addr_data_bus_oe, .origin_rdata, .blank_video, .transfer_done,
        .transfer_deferred);
    vrts_host_model host (.clk, .resetn, .bus_request_out, .grant_delay, .bus_grant_in);

    // Serial clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
        @(negedge clk);
    endtask : pulse

    // Frame start for one edge only, so the request span is seen from its first cycle
    task automatic launch();
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
    endtask : launch

    task automatic write_origin(input logic [ROW_W-1:0] v, input logic frame_alias);
        origin_wdata = v;
        if (frame_alias) pulse(origin_wr_frame);
        else pulse(origin_wr_line);
        @(negedge clk);
    endtask : write_origin

    // One transfer: wait for request, capture the row, time the request and the gap before it
    task automatic xfer(output logic [ROW_W-1:0] row, input logic want_gap, input logic want_span);
        int k;
        int span;
        k = 0;
        span = 0;
        row = '0;
        while (bus_request_out !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
        end
        if (want_gap) check(24'(k), 24'(PRE_N) + 24'h000002);
        while (bus_request_out === 1'b1 && span < 60) begin
            if (shared_addr_data_bus_oe === 1'b1) row = shared_addr_data_bus_out[23:2];
            span++;
            @(negedge clk);
        end
        if (want_span) check(24'(span), 24'(LAG) + 24'h000001);
        check({23'h0, transfer_done}, 24'h000001);
    endtask : xfer

    task automatic restart(input logic [1:0] code, input logic ilace);
        vtg_enable = 1'b0;
        step_code = code;
        interlace = ilace;
        @(negedge clk);
        vtg_enable = 1'b1;
        @(negedge clk);
        launch();
    endtask : restart

    // Main sequence
    initial begin
        {resetn, vtg_enable, interlace, standard_ntsc, origin_wr_line, origin_wr_frame} = 6'h00;
        {frame_start, backporch_start, flyback, line_zero_first_half, step_code} = 6'h00;
        {field_index, shift_edge, grant_delay, origin_wdata, line_remaining} = {2'h3, 4'h1, 22'h0, 16'hffff};
        active_display = 1'b1;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check({bus_request_out, vram_transfer_n, shared_addr_data_bus_oe, transfer_done}, 24'h4);
        write_origin(ORG, 1'b0);
        check(origin_rdata, ORG);
        // Every step code in both formats; the NTSC case drops the second-field offset
        for (int c = 0; c < 8; c++) begin
            standard_ntsc = (c == 6);
            grant_delay = c[0] ? 4'h3 : 4'h1;
            restart(c[1:0], c[2]);
            xfer(r0, 1'b0, 1'b1);
            xfer(r1, 1'b1, 1'b1);
            check(r0, ORG + ((c[2] && !standard_ntsc) ? off_tab[c[1:0]] : 22'h0));
            check(r1 - r0, c[2] ? int_tab[c[1:0]] : non_tab[c[1:0]]);
        end
        standard_ntsc = 1'b0;
        restart(2'h0, 1'b1);
        xfer(r0, 1'b0, 1'b1);
        write_origin(22'h000777, 1'b0);
        write_origin(ORG2, 1'b1);
        check(origin_rdata, ORG2);
        xfer(r1, 1'b0, 1'b1);
        check(r1, r0 + 22'h000001);
        @(negedge clk);
        launch();
        xfer(r0, 1'b0, 1'b1);
        check(r0, ORG2);
        line_zero_first_half = 1'b1;
        @(negedge clk);
        check({23'h0, blank_video}, 24'h000001);
        line_zero_first_half = 1'b0;
        // Short line left: the reload waits for the next back porch
        line_remaining = 16'h0003;
        repeat (8) @(negedge clk);
        check({bus_request_out, transfer_deferred}, 24'h1);
        line_remaining = 16'hffff;
        // Restarted lag stands still until display is active again
        active_display = 1'b0;
        pulse(backporch_start);
        repeat (8) @(negedge clk);
        check({bus_request_out, vram_transfer_n}, 24'h2);
        active_display = 1'b1;
        xfer(r1, 1'b0, 1'b0);
        check(r1, r0 + 22'h000001);
        flyback = 1'b1;
        repeat (8) @(negedge clk);
        pulse(backporch_start);
        check({bus_request_out, transfer_deferred}, 24'h1);
        flyback = 1'b0;
        pulse(backporch_start);
        xfer(r0, 1'b0, 1'b0);
        check(r0, r1 + 22'h000001);
        // Release must wait for a shift clock edge
        shift_edge = 1'b0;
        repeat (2) @(negedge clk);
        pulse(frame_start);
        repeat (14) @(negedge clk);
        check({bus_request_out, vram_transfer_n}, 24'h2);
        shift_edge = 1'b1;
        xfer(r1, 1'b0, 1'b0);
        // Frame start in the pre-request wait, then abort in the middle of the transfer
        @(negedge clk);
        pulse(frame_start);
        repeat (4) @(negedge clk);
        check({bus_request_out, vram_transfer_n}, 24'h2);
        vtg_enable = 1'b0;
        @(negedge clk);
        check({bus_request_out, vram_transfer_n}, 24'h1);
        wrap_up();
    end
endmodule : test_vrts_sequencer
